// file: srf_cal_mem.sv
`timescale 1ns/10ps
module srf_cal_mem (
  input  wire logic        i_wclk,   // System clock
  input  wire logic        i_we,     // Entry write strobe
  input  wire logic [10:0] i_waddr,  // {bank, index}
  input  wire logic [7:0]  i_wdata,  // Port id
  input  wire logic        i_rclk,   // Link clock
  input  wire logic        i_rst_n,  // Async reset, active low
  input  wire logic [10:0] i_raddr,  // {bank, index}
  output logic      [7:0]  o_rdata   // Registered port id
);
  // Main calendar in lower half, shadow in upper
  logic [7:0] mem [0:2047];

  always_ff @(posedge i_wclk)
  begin
    if (i_we)
      mem[i_waddr] <= i_wdata;
  end

  always_ff @(posedge i_rclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata <= 8'h00;
    else
      o_rdata <= mem[i_raddr];
  end
endmodule

// file: srf_far_end.sv
`timescale 1ns/10ps
module srf_far_end (
  input  wire logic        i_lclk,  // Status clock
  input  wire logic        i_rst_n, // Async reset, active low
  input  wire logic [1:0]  i_stat,  // Received status word
  input  wire logic        i_sw,    // Select word expected
  input  wire logic [15:0] i_len,   // Calendar length
  input  wire logic [7:0]  i_rep,   // Calendar repetitions
  output logic      [15:0] o_good,  // Frames with good check word
  output logic      [15:0] o_bad,   // Frames with bad check word or no idle word after it
  output logic      [1:0]  o_sel,   // Select word of last good frame
  output logic      [31:0] o_words  // Slot words of last good frame
);
  int n;
  int t;
  logic [1:0]  ph;
  logic [1:0]  d;
  logic [1:0]  prev;
  logic [1:0]  sel;
  logic [31:0] w;
  always @(posedge i_lclk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      ph = 2'h0;
      prev = 2'h0;
      o_good = 16'h0;
      o_bad = 16'h0;
      o_sel = 2'h0;
      o_words = 32'h0;
    end
    else
    begin
      t = i_sw + i_len * i_rep;
      if (ph == 2'h1 && n == t)
      begin
        if (i_stat === (d ^ 2'h3))
        begin
          o_good = o_good + 16'h1;
          o_sel = sel;
          o_words = w;
        end
        else
          o_bad = o_bad + 16'h1;
        ph = 2'h2;
      end
      else if (ph == 2'h2)
      begin
        if (i_stat !== 2'h3)
          o_bad = o_bad + 16'h1;
        ph = 2'h0;
      end
      else if (ph == 2'h1 && i_stat == 2'h3)
        ph = 2'h0; // Link went idle mid-frame
      else if (ph == 2'h1 || (prev == 2'h3 && i_stat != 2'h3))
      begin
        if (ph == 2'h0)
        begin
          n = 0;
          d = 2'h0;
          w = 32'h0;
        end
        ph = 2'h1;
        d = {d[0], d[1]} ^ i_stat;
        if (i_sw && n == 0)
          sel = i_stat;
        else
          w = {w[29:0], i_stat};
        n++;
      end
      prev = i_stat;
    end
endmodule

// file: srf_gen.sv
`timescale 1ns/10ps
`include "srf_regs.svh"
module srf_gen
  import srf_pkg::*;
(
  input  wire logic        i_clk,        // System clock, 40 MHz
  input  wire logic        i_rst_n,      // Async reset, active low
  input  wire logic [17:0] i_sb_addr,    // System bus byte address
  input  wire logic        i_sb_wr,      // Write strobe
  input  wire logic        i_sb_rd,      // Read strobe
  input  wire logic [7:0]  i_sb_wdata,   // Write data
  output logic      [7:0]  o_sb_rdata,   // Read data
  output logic             o_sb_ack,     // Access done pulse
  input  wire logic        i_lclk,       // Status link clock
  input  wire logic        i_rx_aligned, // Receive data aligned
  input  wire logic        i_fill_34,    // Port fill at least 3/4
  input  wire logic        i_fill_12,    // Port fill at least 1/2
  input  wire logic        i_ext_en,     // User status enable
  input  wire logic [1:0]  i_ext_stat,   // User status code
  output logic      [7:0]  o_cal_port,   // Port id being polled
  output logic      [1:0]  o_ttl_stat,   // LVTTL status bus
  output logic             o_ttl_oe,     // LVTTL drive enable
  output logic      [1:0]  o_lvds_stat,  // LVDS status bus
  output logic             o_lvds_oe     // LVDS drive enable
);
  srf_sys_t   s_q, s_d;
  srf_lnk_t   l_q, l_d;
  logic       tog_s;
  logic       seen_s;
  logic       aligned_s;
  logic [5:0] rb_s;
  logic       mem_we;
  logic [10:0] mem_waddr;
  logic       cal_hit;

  // System domain: register file and calendar write port

  assign cal_hit = (i_sb_addr[17:11] == `SRF_CAL_PAGE);
  assign mem_we = i_sb_wr & s_q.mem_sel & cal_hit
                & (i_sb_addr[9:0] != `SRF_CAL_LAST);
  assign mem_waddr = {i_sb_addr[10], i_sb_addr[9:0]};

  always_comb
  begin
    s_d = s_q;
    s_d.ack = i_sb_wr | i_sb_rd;
    if (i_sb_wr)
    begin
      case (i_sb_addr)
        `SRF_OFS_REPEAT:
          s_d.cfg.rep = i_sb_wdata;
        `SRF_OFS_LEN_LO:
          s_d.cfg.len[7:0] = i_sb_wdata;
        `SRF_OFS_LEN_HI:
          s_d.cfg.len[15:8] = i_sb_wdata;
        `SRF_OFS_SWITCH:
        begin
          s_d.cfg.sw_en = i_sb_wdata[`SRF_BIT_SW_EN];
          s_d.cfg.cal_sel = i_sb_wdata[`SRF_BIT_CAL_SEL];
        end
        `SRF_OFS_MEMSEL:
          s_d.mem_sel = i_sb_wdata[`SRF_BIT_MEMSEL];
        `SRF_OFS_CTRL:
        begin
          s_d.cfg.dis = i_sb_wdata[`SRF_BIT_DIS];
          s_d.cfg.io_sel = i_sb_wdata[`SRF_BIT_IO_SEL];
        end
        default:
          s_d.cfg = s_q.cfg;
      endcase
      // Remember the change until the link side can take it
      if (!cal_hit)
        s_d.pend = 1'b1;
    end
    // One announce in flight; two quick flips could cancel out
    if (s_d.pend && (s_q.tog == seen_s))
    begin
      s_d.tog = ~s_q.tog;
      s_d.pend = 1'b0;
    end
    if (i_sb_rd)
    begin
      case (i_sb_addr)
        `SRF_OFS_REPEAT:
          s_d.rdata = s_q.cfg.rep;
        `SRF_OFS_LEN_LO:
          s_d.rdata = s_q.cfg.len[7:0];
        `SRF_OFS_LEN_HI:
          s_d.rdata = s_q.cfg.len[15:8];
        `SRF_OFS_SWITCH:
          s_d.rdata = {6'h00, s_q.cfg.cal_sel, s_q.cfg.sw_en};
        `SRF_OFS_MEMSEL:
          s_d.rdata = {7'h00, s_q.mem_sel};
        `SRF_OFS_CTRL:
          s_d.rdata = {6'h00, s_q.cfg.io_sel, s_q.cfg.dis};
        `SRF_OFS_STATE:
          s_d.rdata = {2'h0, rb_s};
        default:
          s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_q <= '0;
      s_q.cfg.dis <= `SRF_RST_DIS;
      s_q.rdata <= `SRF_RST_BYTE;
    end
    else
      s_q <= s_d;
  end

  assign o_sb_rdata = s_q.rdata;
  assign o_sb_ack = s_q.ack;

  // Crossings: config announce toggle, alignment pin, state readback

  srf_sync #(.W(1)) u_tog_sync (
    .i_clk   (i_lclk),
    .i_rst_n (i_rst_n),
    .i_d     (s_q.tog),
    .o_q     (tog_s)
  );

  srf_sync #(.W(1)) u_align_sync (
    .i_clk   (i_lclk),
    .i_rst_n (i_rst_n),
    .i_d     (i_rx_aligned),
    .o_q     (aligned_s)
  );

  // Readback only; a torn state code is harmless here
  srf_sync #(.W(6)) u_state_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({aligned_s, l_q.state}),
    .o_q     (rb_s)
  );

  // Link side echoes the announce it has taken
  srf_sync #(.W(1)) u_seen_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     (l_q.tog_seen),
    .o_q     (seen_s)
  );

  srf_cal_mem u_cal_mem (
    .i_wclk  (i_clk),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (i_sb_wdata),
    .i_rclk  (i_lclk),
    .i_rst_n (i_rst_n),
    .i_raddr ({l_d.bank, l_d.idx}),
    .o_rdata (o_cal_port)
  );

  // Link domain: status frame machine, one word per link cycle

  logic [1:0] port_code;
  logic [1:0] word;
  logic       emit;

  // Status of the port polled this cycle
  always_comb
  begin
    if (i_fill_34)
      port_code = `SRF_CD_SATIS;
    else if (i_ext_en)
      port_code = i_ext_stat;
    else if (i_fill_12)
      port_code = `SRF_CD_HUNGRY;
    else
      port_code = `SRF_CD_STARVE;
  end

  always_comb
  begin
    l_d = l_q;
    word = `SRF_CD_FRAME;
    emit = 1'b0;
    // Config is stable by the time the toggle edge arrives
    if (tog_s != l_q.tog_seen)
    begin
      l_d.tog_seen = tog_s;
      l_d.cfg = s_q.cfg;
    end
    // One state step per link cycle, link clock = data rate / 8
    case (l_q.state)
      srf_st_dis:
      begin
        word = `SRF_CD_FRAME;
        l_d.state = srf_st_sync;
      end
      srf_st_sync:
      begin
        word = `SRF_CD_FRAME;
        l_d.len_cnt = l_q.cfg.len;
        l_d.rep_cnt = l_q.cfg.rep;
        l_d.idx = 10'h000;
        l_d.dip = 2'h0;
        // Bank frozen per frame keeps switching hitless
        l_d.bank = l_q.cfg.sw_en & l_q.cfg.cal_sel;
        if (l_q.cfg.sw_en)
          l_d.state = srf_st_switch;
        else
          l_d.state = srf_st_cal;
      end
      srf_st_switch:
      begin
        if (l_q.bank)
          word = `SRF_CD_SEL_SHAD;
        else
          word = `SRF_CD_SEL_MAIN;
        emit = 1'b1;
        l_d.state = srf_st_cal;
      end
      srf_st_cal:
      begin
        word = port_code;
        emit = 1'b1;
        l_d.len_cnt = l_q.len_cnt - 16'h0001;
        l_d.idx = l_q.idx + 10'h001;
        // Zero lengths behave as one so a frame always ends
        if (l_q.len_cnt <= 16'h0001)
        begin
          if (l_q.rep_cnt <= 8'h01)
            l_d.state = srf_st_dip;
          else
          begin
            l_d.rep_cnt = l_q.rep_cnt - 8'h01;
            l_d.len_cnt = l_q.cfg.len;
            l_d.idx = 10'h000;
          end
        end
      end
      srf_st_dip:
      begin
        word = l_q.dip ^ `SRF_DIP_MASK;
        l_d.state = srf_st_sync;
      end
      default:
      begin
        word = `SRF_CD_FRAME;
        l_d.state = srf_st_dis;
      end
    endcase
    // Diagonal parity: shift columns by one, fold in word
    if (emit)
      l_d.dip = {l_q.dip[0], l_q.dip[1]} ^ word;
    if (l_d.cfg.dis || !aligned_s)
    begin
      l_d.state = srf_st_dis;
      word = `SRF_CD_FRAME;
    end
    // Only the chosen buffer drives; the other idles low
    l_d.ttl_oe = ~l_d.cfg.io_sel;
    l_d.lvds_oe = l_d.cfg.io_sel;
    l_d.ttl = l_d.cfg.io_sel ? 2'h0 : word;
    l_d.lvds = l_d.cfg.io_sel ? word : 2'h0;
  end

  always_ff @(posedge i_lclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      l_q <= '0;
      l_q.cfg.dis <= `SRF_RST_DIS;
      l_q.state <= srf_st_dis;
      l_q.ttl <= `SRF_CD_FRAME;
      l_q.ttl_oe <= 1'b1;
    end
    else
      l_q <= l_d;
  end

  assign o_ttl_stat = l_q.ttl;
  assign o_ttl_oe = l_q.ttl_oe;
  assign o_lvds_stat = l_q.lvds;
  assign o_lvds_oe = l_q.lvds_oe;
endmodule

// file: srf_gen_sva.sv
`timescale 1ns/10ps
`include "srf_regs.svh"
module srf_chk (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [17:0] i_sb_addr,
  input wire logic        i_sb_wr,
  input wire logic        i_sb_rd,
  input wire logic [7:0]  i_sb_wdata,
  input wire logic [7:0]  o_sb_rdata,
  input wire logic        o_sb_ack,
  input wire logic        i_lclk,
  input wire logic        i_rx_aligned,
  input wire logic [1:0]  o_ttl_stat,
  input wire logic        o_ttl_oe,
  input wire logic [1:0]  o_lvds_stat,
  input wire logic        o_lvds_oe
);
  logic [1:0] stat;
  assign stat = o_ttl_oe ? o_ttl_stat : o_lvds_stat;
  a_ack_follows:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_sb_wr || i_sb_rd |=> o_sb_ack) else $error("no ack");
  a_ack_cause:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_sb_ack |-> $past(i_sb_wr || i_sb_rd)) else $error("stray ack");
  a_rdata_holds:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !$past(i_sb_rd) |-> $stable(o_sb_rdata)) else $error("rdata moved");
  a_unmapped_zero:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_sb_rd && i_sb_addr == 18'h30930 |=> o_sb_rdata == 8'h00)
      else $error("unmapped read");
  a_repeat_back:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_sb_wr && i_sb_addr == `SRF_OFS_REPEAT ##2
      i_sb_rd && i_sb_addr == `SRF_OFS_REPEAT
      |=> o_sb_rdata == $past(i_sb_wdata, 3)) else $error("repeat lost");
  // Two sync flops plus the output register
  a_dis_pattern:
    assert property (@(posedge i_lclk) disable iff (!i_rst_n)
      !i_rx_aligned [*6] |-> stat == 2'h3) else $error("not idle");
  a_one_buffer:
    assert property (@(posedge i_lclk) disable iff (!i_rst_n)
      o_ttl_oe != o_lvds_oe) else $error("buffer enables");
  a_lvds_quiet:
    assert property (@(posedge i_lclk) disable iff (!i_rst_n)
      !o_lvds_oe |-> o_lvds_stat == 2'h0) else $error("lvds not quiet");
  c_lvds: cover property (@(posedge i_lclk) o_lvds_oe);
  c_align_lost: cover property (@(posedge i_lclk) $fell(i_rx_aligned));
  c_read: cover property (@(posedge i_clk) o_sb_ack && o_sb_rdata != 0);
endmodule
bind srf_gen srf_chk srf_chk_i (.*);

// file: srf_gen_tb.sv
`timescale 1ns/10ps
`include "srf_regs.svh"
module srf_gen_tb;
  import srf_pkg::*;
  logic        i_clk = 0, i_rst_n = 0, i_lclk = 0, i_rx_aligned = 0;
  logic        i_sb_wr = 0, i_sb_rd = 0, i_fill_34 = 0, i_fill_12 = 0;
  logic        i_ext_en = 0, o_sb_ack, o_ttl_oe, o_lvds_oe, sw = 0;
  logic [17:0] i_sb_addr = 0;
  logic [7:0]  i_sb_wdata = 0, o_sb_rdata, o_cal_port, rep = 1, v;
  logic [1:0]  i_ext_stat = 0, o_ttl_stat, o_lvds_stat, stat, sel;
  logic [15:0] len = 1, good, bad;
  logic [31:0] words;
  logic [7:0]  cal [2][16];
  int          fail_count = 0, checks = 0;
  always #12.5 i_clk = ~i_clk;
  always #32 i_lclk = ~i_lclk;
  assign stat = o_ttl_oe ? o_ttl_stat : o_lvds_stat;
  srf_gen srf_gen_i (.*);
  srf_far_end srf_far_end_i (.i_lclk(i_lclk), .i_rst_n(i_rst_n),
    .i_stat(stat), .i_sw(sw), .i_len(len), .i_rep(rep), .o_good(good),
    .o_bad(bad), .o_sel(sel), .o_words(words));
  // Per-port status taken from port id bits
  always @(negedge i_lclk)
  begin
    i_fill_34 <= o_cal_port[7];
    i_fill_12 <= o_cal_port[6];
    i_ext_en <= o_cal_port[5];
    i_ext_stat <= (o_cal_port[1:0] == 2'h3) ? 2'h0 : o_cal_port[1:0];
  end
  function automatic logic [1:0] code(input logic [7:0] p);
    if (p[7])
      return 2'h2;
    if (p[5])
      return (p[1:0] == 2'h3) ? 2'h0 : p[1:0];
    return p[6] ? 2'h1 : 2'h0;
  endfunction
  function automatic logic [31:0] exp_words(input logic b);
    logic [31:0] r = 0;
    for (int k = 0; k < len * rep; k++)
      r = {r[29:0], code(cal[b][k % len])};
    return r;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_sb_addr = a;
    i_sb_wdata = d;
    i_sb_wr = 1;
    @(negedge i_clk);
    i_sb_wr = 0;
    chk("wr ack", o_sb_ack, 1);
  endtask
  task automatic rd(input logic [17:0] a, input logic [7:0] e);
    @(negedge i_clk);
    i_sb_addr = a;
    i_sb_rd = 1;
    @(negedge i_clk);
    i_sb_rd = 0;
    chk("rd ack", o_sb_ack, 1);
    chk("rd data", o_sb_rdata, e);
  endtask
  task automatic frames(input int k);
    int g;
    g = good;
    for (int i = 0; i < 3000 && good < g + k; i++)
      @(negedge i_lclk);
    chk("frames", good >= g + k, 1);
  endtask
  // Frames near a change may mix old and new settings
  task automatic settle;
    logic [15:0] b0;
    repeat (32) @(negedge i_lclk);
    frames(1);
    b0 = bad;
    frames(2);
    chk("bad frames", bad, b0);
  endtask
  task automatic complete_run;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #400us;
    fail_count++;
    complete_run();
  end
  initial
  begin
    void'($urandom(64));
    repeat (3) @(negedge i_lclk);
    i_rst_n = 1;
    chk("idle", {o_ttl_oe, o_ttl_stat, o_lvds_oe}, 4'hE);
    repeat (2) @(negedge i_clk);
    rd(`SRF_OFS_STATE, 8'h01);
    rd(`SRF_OFS_LEN_HI, `SRF_RST_BYTE);
    rd(`SRF_OFS_CTRL, `SRF_RST_BYTE);
    rd(18'h30930, 8'h00);
    v = 8'($urandom);
    wr(`SRF_OFS_REPEAT, v);
    rd(`SRF_OFS_REPEAT, v);
    wr(`SRF_OFS_MEMSEL, 8'h01);
    for (int b = 0; b < 2; b++)
      for (int i = 0; i < 16; i++)
      begin
        cal[b][i] = (i == 0) ? 8'h80 : (i == 1) ? 8'h21 : 8'($urandom);
        wr(18'h31000 + 18'(b * 1024 + i), cal[b][i]);
      end
    wr(`SRF_OFS_MEMSEL, 8'h00);
    wr(18'h31000, 8'h41);
    for (int it = 0; it < 2; it++)
    begin
      len = (it == 0) ? 16'h1 : 16'(1 + $urandom % 8);
      rep = (it == 0) ? 8'h2 : 8'(1 + $urandom % 2);
      wr(`SRF_OFS_REPEAT, rep);
      wr(`SRF_OFS_LEN_LO, len[7:0]);
      wr(`SRF_OFS_LEN_HI, len[15:8]);
      @(negedge i_lclk);
      i_rx_aligned = 1;
      for (int s = 0; s < 3; s++)
      begin
        sw = (s != 0);
        wr(`SRF_OFS_SWITCH, s == 0 ? 8'h00 : s == 1 ? 8'h01 : 8'h03);
        settle();
        chk("words", words, exp_words(s == 2));
        if (sw)
          chk("sel", sel, s == 1 ? 2'h1 : 2'h2);
      end
    end
    wr(`SRF_OFS_CTRL, 8'h02);
    settle();
    chk("oe", {o_ttl_oe, o_lvds_oe}, 2'h1);
    chk("lvds words", words, exp_words(1));
    wr(`SRF_OFS_CTRL, 8'h03);
    repeat (4) @(negedge i_lclk);
    repeat (8)
    begin
      @(negedge i_lclk);
      chk("disabled", stat, 2'h3);
    end
    rd(`SRF_OFS_STATE, 8'h21);
    wr(`SRF_OFS_CTRL, 8'h00);
    settle();
    @(negedge i_lclk);
    i_rx_aligned = 0;
    repeat (8) @(negedge i_lclk);
    chk("unaligned", stat, 2'h3);
    rd(`SRF_OFS_STATE, 8'h01);
    complete_run();
  end
endmodule

// file: srf_pkg.sv
package srf_pkg;
  typedef enum logic [4:0] {
    srf_st_dis    = 5'h01,
    srf_st_sync   = 5'h02,
    srf_st_switch = 5'h04,
    srf_st_cal    = 5'h08,
    srf_st_dip    = 5'h10
  } srf_state_t;

  typedef struct packed {
    logic [7:0]  rep;
    logic [15:0] len;
    logic        sw_en;
    logic        cal_sel;
    logic        dis;
    logic        io_sel;
  } srf_cfg_t;

  typedef struct packed {
    srf_cfg_t   cfg;
    logic       mem_sel;
    logic       tog;
    logic       pend;
    logic [7:0] rdata;
    logic       ack;
  } srf_sys_t;

  typedef struct packed {
    srf_cfg_t    cfg;
    logic        tog_seen;
    srf_state_t  state;
    logic [15:0] len_cnt;
    logic [7:0]  rep_cnt;
    logic [9:0]  idx;
    logic        bank;
    logic [1:0]  dip;
    logic [1:0]  ttl;
    logic        ttl_oe;
    logic [1:0]  lvds;
    logic        lvds_oe;
  } srf_lnk_t;
endpackage

// file: srf_regs.svh
`ifndef SRF_REGS_SVH
`define SRF_REGS_SVH
`define SRF_OFS_REPEAT  18'h30900
`define SRF_OFS_LEN_LO  18'h30901
`define SRF_OFS_LEN_HI  18'h30902
`define SRF_OFS_SWITCH  18'h30916
`define SRF_OFS_MEMSEL  18'h30917
`define SRF_OFS_CTRL    18'h30918
`define SRF_OFS_STATE   18'h30919
`define SRF_CAL_PAGE    7'h62
`define SRF_CAL_LAST    10'h3FF
`define SRF_BIT_SW_EN   0
`define SRF_BIT_CAL_SEL 1
`define SRF_BIT_MEMSEL  0
`define SRF_BIT_DIS     0
`define SRF_BIT_IO_SEL  1
`define SRF_RST_DIS     1'h0
`define SRF_RST_BYTE    8'h00
`define SRF_CD_STARVE   2'h0
`define SRF_CD_HUNGRY   2'h1
`define SRF_CD_SATIS    2'h2
`define SRF_CD_FRAME    2'h3
`define SRF_CD_SEL_MAIN 2'h1
`define SRF_CD_SEL_SHAD 2'h2
`define SRF_DIP_MASK    2'h3
`endif

// file: srf_sync.sv
`timescale 1ns/10ps
module srf_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,   // Destination clock
  input  wire logic         i_rst_n, // Async reset, active low
  input  wire logic [W-1:0] i_d,     // Foreign-domain level
  output logic      [W-1:0] o_q      // Synchronised level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } srf_sync_t;

  srf_sync_t q, d;

  always_comb
  begin
    d.s1 = i_d;
    d.s2 = q.s1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign o_q = q.s2;
endmodule
